// [pmbus_host_model.sv]
// Behavioural bus host that clocks the management slave
`timescale 1ns/10ps
`default_nettype none
module pmbus_host_model (
   input  wire logic clk,   // Pacing clock
   input  wire logic sda,   // Resolved data line
   output var  logic scl,   // Bus clock to slave
   output var  logic sda_h  // Host data drive, 0 pulls low
);
   initial begin
      scl = 1'b1;
      sda_h = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Start, also serves as repeated start
   task automatic start();
      w(4);
      sda_h = 1'b1;
      w(9);
      scl = 1'b1;
      w(13);
      sda_h = 1'b0;
      w(13);
      scl = 1'b0;
   endtask
   task automatic stop();
      w(4);
      sda_h = 1'b0;
      w(9);
      scl = 1'b1;
      w(13);
      sda_h = 1'b1;
      w(13);
   endtask
   // Data changes only while the clock is low, about 385 kHz
   task automatic bit_io(input logic b, output logic r);
      w(4);
      sda_h = b;
      w(9);
      scl = 1'b1;
      w(13);
      r = sda;
      scl = 1'b0;
   endtask
   task automatic wr(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, ack);
   endtask
   // Comp bits at 0 act as a competing device during arbitration
   task automatic rd(input logic [7:0] comp, input logic a,
                     output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(comp[i], r);
         d[i] = r;
      end
      bit_io(a, r);
   endtask
endmodule
`default_nettype wire

// [pmbus_slave_interface.sv]
// Management bus slave: framing, check byte, registers and alert answer
`timescale 1ns/10ps
`default_nettype none
`include "pmbus_slave_regs.svh"
module pmbus_slave_interface
   import pmbus_slave_pkg::*;
#(
   parameter logic [15:0] BLOCK_ID = 16'h5a01  // Arbitrary identity value
) (
   input  wire logic        clk,         // System clock
   input  wire logic        rst_n,       // Async reset, active low
   input  wire logic        scl,         // Bus clock from host
   input  wire logic        sda_i,       // Data line level
   output var  logic        sda_o,       // Data drive value
   output var  logic        sda_oe_n,    // Data drive enable, low
   output var  logic        alert_o,     // Alert drive value
   output var  logic        alert_oe_n,  // Alert drive enable, low
   input  wire logic [3:0]  addr_code,   // Strap conversion code
   input  wire logic        alert_req,   // Warning event pulse
   input  wire logic [15:0] meas_vout,   // Measured output voltage
   output var  logic [15:0] setpoint,    // Output set-point
   output var  logic [15:0] margin_hi,   // High margin
   output var  logic [15:0] margin_lo,   // Low margin
   output var  logic [15:0] scale_ratio, // Loop scale ratio
   output var  logic        cml_err      // Communication error flag
);
   // Bus clock domain: bit capture and an event toggle per rising edge
   logic rx_bit_scl_r;
   logic rise_tgl_r;
   logic rise_tgl_nxt;
   always_comb begin
      rise_tgl_nxt = ~rise_tgl_r;
   end
   always_ff @(posedge scl or negedge rst_n) begin
      if (!rst_n) begin
         rx_bit_scl_r <= 1'b0;
         rise_tgl_r   <= 1'b0;
      end else begin
         rx_bit_scl_r <= sda_i;
         rise_tgl_r   <= rise_tgl_nxt;
      end
   end

   // Synchronisers; second and third stages feed edge detection
   logic [2:0] tgl_s_r;
   logic [2:0] scl_s_r;
   logic [2:0] sda_s_r;
   logic [3:0] code_s1_r;
   logic [3:0] code_s2_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tgl_s_r   <= 3'h0;
         scl_s_r   <= 3'h7;
         sda_s_r   <= 3'h7;
      end else begin
         tgl_s_r   <= {tgl_s_r[1:0], rise_tgl_r};
         scl_s_r   <= {scl_s_r[1:0], scl};
         sda_s_r   <= {sda_s_r[1:0], sda_i};
      end
   end
   // Strap code keeps moving during reset, so it is valid at release
   always_ff @(posedge clk) begin
      code_s1_r <= addr_code;
      code_s2_r <= code_s1_r;
   end
   logic rise_ev;
   logic fall_ev;
   logic start_ev;
   logic stop_ev;
   logic scl_hi;
   always_comb begin
      scl_hi   = scl_s_r[1] & scl_s_r[2];
      rise_ev  = tgl_s_r[1] ^ tgl_s_r[2];
      fall_ev  = scl_s_r[2] & ~scl_s_r[1];
      start_ev = scl_hi & sda_s_r[2] & ~sda_s_r[1];
      stop_ev  = scl_hi & ~sda_s_r[2] & sda_s_r[1];
   end

   // Command properties
   function automatic logic [1:0] wr_len(byte_t c);
      case (c)
         `OFS_SETPOINT, `OFS_MARGIN_HI,
         `OFS_MARGIN_LO, `OFS_SCALE: wr_len = 2'h2;
         `CMD_STATUS:                wr_len = 2'h1;
         `CMD_CLR_FAULT:             wr_len = 2'h0;
         default:                    wr_len = `LEN_BAD;
      endcase
   endfunction

   // Protocol state
   link_state_e st_r, st_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   byte_t       sr_r, sr_nxt;
   logic [2:0]  idx_r, idx_nxt;
   byte_t       cmd_r, cmd_nxt;
   logic        cmd_ok_r, cmd_ok_nxt;
   logic        rd_r, rd_nxt;
   logic        ara_r, ara_nxt;
   byte_t       tx_r, tx_nxt;
   logic [2:0]  txi_r, txi_nxt;
   byte_t       crc_r, crc_nxt;
   byte_t       wlo_r, wlo_nxt;
   byte_t       whi_r, whi_nxt;
   logic [1:0]  dcnt_r, dcnt_nxt;
   logic        pend_r, pend_nxt;
   logic        hack_r, hack_nxt;
   logic        oe_n_r, oe_n_nxt;
   logic        alert_r, alert_nxt;
   logic        cml_r, cml_nxt;
   logic [6:0]  own_r, own_nxt;
   logic        strap_r, strap_nxt;
   logic [15:0] sp_r, sp_nxt;
   logic [15:0] mh_r, mh_nxt;
   logic [15:0] ml_r, ml_nxt;
   logic [15:0] sc_r, sc_nxt;
   logic        commit;
   logic        pec_bad;
   logic        ara_done;
   logic        lost;
   logic        err;
   logic        load;
   logic [15:0] rd_word;
   logic [2:0]  rd_n;
   byte_t       b;
   byte_t       txb;

   always_comb begin
      st_nxt     = st_r;
      cnt_nxt    = cnt_r;
      sr_nxt     = sr_r;
      idx_nxt    = idx_r;
      cmd_nxt    = cmd_r;
      cmd_ok_nxt = cmd_ok_r;
      rd_nxt     = rd_r;
      ara_nxt    = ara_r;
      tx_nxt     = tx_r;
      txi_nxt    = txi_r;
      crc_nxt    = crc_r;
      wlo_nxt    = wlo_r;
      whi_nxt    = whi_r;
      dcnt_nxt   = dcnt_r;
      pend_nxt   = pend_r;
      hack_nxt   = hack_r;
      oe_n_nxt   = oe_n_r;
      alert_nxt  = alert_r;
      cml_nxt    = cml_r;
      own_nxt    = own_r;
      strap_nxt  = 1'b1;
      sp_nxt     = sp_r;
      mh_nxt     = mh_r;
      ml_nxt     = ml_r;
      sc_nxt     = sc_r;
      commit     = 1'b0;
      pec_bad    = 1'b0;
      ara_done   = 1'b0;
      lost       = 1'b0;
      err        = 1'b0;
      load       = 1'b0;
      b          = sr_r;
      // Strap caught once, after reset release
      if (!strap_r) begin
         own_nxt = `ADDR_BASE + {3'h0, code_s2_r};
      end
      // Read data source for the current command
      case (cmd_r)
         `OFS_SETPOINT:  rd_word = sp_r;
         `OFS_MARGIN_HI: rd_word = mh_r;
         `OFS_MARGIN_LO: rd_word = ml_r;
         `OFS_SCALE:     rd_word = sc_r;
         `OFS_VOUT_MEAS: rd_word = meas_vout;
         default:        rd_word = BLOCK_ID;
      endcase
      if (ara_r || !cmd_ok_r || cmd_r == `CMD_STATUS) begin
         rd_n = 3'h1;
      end else if (cmd_r == `CMD_BLOCK_ID) begin
         rd_n = 3'h3;
      end else begin
         rd_n = 3'h2;
      end
      // Byte to send; after the data comes the check byte
      if (txi_r >= rd_n) begin
         txb = crc_r;
      end else if (ara_r) begin
         txb = {own_r, 1'b1};
      end else if (!cmd_ok_r || cmd_r == `CMD_STATUS) begin
         txb = 8'h00;
         txb[`STAT_CML_BIT] = cml_r;
      end else if (cmd_r == `CMD_BLOCK_ID) begin
         txb = (txi_r == 3'h0) ? `BLOCK_LEN :
               (txi_r == 3'h1) ? rd_word[7:0] : rd_word[15:8];
      end else begin
         txb = (txi_r == 3'h0) ? rd_word[7:0] : rd_word[15:8];
      end
      if (start_ev) begin
         st_nxt   = ST_RXB;
         cnt_nxt  = 4'h0;
         idx_nxt  = 3'h0;
         oe_n_nxt = 1'b1;
         ara_nxt  = 1'b0;
         if (st_r == ST_IDLE) begin
            crc_nxt = 8'h00;
         end
      end else if (stop_ev) begin
         st_nxt     = ST_IDLE;
         oe_n_nxt   = 1'b1;
         commit     = pend_r & cmd_ok_r;
         pend_nxt   = 1'b0;
         cmd_ok_nxt = 1'b0;
      end else begin
         case (st_r)
            ST_RXB: begin
               if (rise_ev) begin
                  sr_nxt  = {sr_r[6:0], rx_bit_scl_r};
                  cnt_nxt = cnt_r + 4'h1;
               end else if (fall_ev && cnt_r == `BITS_BYTE) begin
                  crc_nxt  = crc8_step(crc_r, b);
                  oe_n_nxt = 1'b0;
                  st_nxt   = ST_RACK;
                  if (idx_r != 3'h7) begin
                     idx_nxt = idx_r + 3'h1;
                  end
                  if (idx_r == 3'h0) begin
                     rd_nxt  = b[0];
                     txi_nxt = 3'h0;
                     if (b[7:1] == `ARA_ADDR && b[0] && alert_r) begin
                        ara_nxt = 1'b1;
                     end else if (b[7:1] != own_r) begin
                        oe_n_nxt = 1'b1;
                        st_nxt   = ST_SKIP;
                     end
                     if (!b[0]) begin
                        cmd_ok_nxt = 1'b0;
                        pend_nxt   = 1'b0;
                     end
                  end else if (!cmd_ok_r) begin
                     cmd_nxt    = b;
                     cmd_ok_nxt = 1'b1;
                     dcnt_nxt   = 2'h0;
                     pend_nxt   = (wr_len(b) == 2'h0);
                     if (wr_len(b) == `LEN_BAD && b != `OFS_VOUT_MEAS &&
                         b != `CMD_BLOCK_ID) begin
                        err = 1'b1;
                     end
                  end else if (wr_len(cmd_r) == `LEN_BAD) begin
                     err = 1'b1;
                  end else if (dcnt_r < wr_len(cmd_r)) begin
                     if (dcnt_r == 2'h0) begin
                        wlo_nxt = b;
                     end else begin
                        whi_nxt = b;
                     end
                     dcnt_nxt = dcnt_r + 2'h1;
                     pend_nxt = (dcnt_r + 2'h1 == wr_len(cmd_r));
                  end else if (dcnt_r == wr_len(cmd_r)) begin
                     dcnt_nxt = dcnt_r + 2'h1;
                     pend_nxt = 1'b0;
                     if (b == crc_r) begin
                        commit = 1'b1;
                     end else begin
                        pec_bad = 1'b1;
                     end
                  end else begin
                     err = 1'b1;
                  end
                  if (err) begin
                     oe_n_nxt = 1'b1;
                     st_nxt   = ST_SKIP;
                     pend_nxt = 1'b0;
                  end
               end
            end
            ST_RACK: begin
               if (fall_ev) begin
                  cnt_nxt = 4'h0;
                  if (rd_r) begin
                     load = 1'b1;
                  end else begin
                     oe_n_nxt = 1'b1;
                     st_nxt   = ST_RXB;
                  end
               end
            end
            ST_TXB: begin
               if (rise_ev) begin
                  cnt_nxt = cnt_r + 4'h1;
                  if (oe_n_r && !rx_bit_scl_r) begin
                     lost   = 1'b1;
                     st_nxt = ST_SKIP;
                  end
               end else if (fall_ev) begin
                  if (cnt_r == `BITS_BYTE) begin
                     oe_n_nxt = 1'b1;
                     st_nxt   = ST_TACK;
                     ara_done = ara_r & (txi_r == 3'h1);
                  end else begin
                     oe_n_nxt = tx_r[6];
                     tx_nxt   = {tx_r[6:0], 1'b1};
                  end
               end
            end
            ST_TACK: begin
               if (rise_ev) begin
                  hack_nxt = rx_bit_scl_r;
               end else if (fall_ev) begin
                  cnt_nxt = 4'h0;
                  if (!hack_r) begin
                     load = 1'b1;
                  end else begin
                     st_nxt = ST_SKIP;
                  end
               end
            end
            default: begin
            end
         endcase
      end
      if (load) begin
         tx_nxt   = txb;
         crc_nxt  = crc8_step(crc_r, txb);
         oe_n_nxt = txb[7];
         st_nxt   = ST_TXB;
         if (txi_r != 3'h7) begin
            txi_nxt = txi_r + 3'h1;
         end
      end
      if (commit) begin
         case (cmd_r)
            `OFS_SETPOINT:  sp_nxt = {whi_r, wlo_r};
            `OFS_MARGIN_HI: mh_nxt = {whi_r, wlo_r};
            `OFS_MARGIN_LO: ml_nxt = {whi_r, wlo_r};
            `OFS_SCALE:     sc_nxt = {whi_r, wlo_r};
            `CMD_STATUS: begin
               if (wlo_r[`STAT_CML_BIT]) begin
                  cml_nxt = 1'b0;
               end
            end
            `CMD_CLR_FAULT: cml_nxt = 1'b0;
            default: begin
            end
         endcase
      end
      if (ara_done) begin
         alert_nxt = 1'b0;
      end
      // Setting beats clearing in the same cycle
      if (pec_bad || err) begin
         cml_nxt   = 1'b1;
         alert_nxt = 1'b1;
      end
      if (alert_req) begin
         alert_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r     <= ST_IDLE;
         cnt_r    <= 4'h0;
         sr_r     <= 8'h00;
         idx_r    <= 3'h0;
         cmd_r    <= 8'h00;
         cmd_ok_r <= 1'b0;
         rd_r     <= 1'b0;
         ara_r    <= 1'b0;
         tx_r     <= 8'hff;
         txi_r    <= 3'h0;
         crc_r    <= 8'h00;
         wlo_r    <= 8'h00;
         whi_r    <= 8'h00;
         dcnt_r   <= 2'h0;
         pend_r   <= 1'b0;
         hack_r   <= 1'b1;
         oe_n_r   <= 1'b1;
         alert_r  <= 1'b0;
         cml_r    <= 1'b0;
         own_r    <= `ADDR_BASE;
         strap_r  <= 1'b0;
         sp_r     <= `RST_SETPOINT;
         mh_r     <= `RST_MARGIN_HI;
         ml_r     <= `RST_MARGIN_LO;
         sc_r     <= `RST_SCALE;
      end else begin
         st_r     <= st_nxt;
         cnt_r    <= cnt_nxt;
         sr_r     <= sr_nxt;
         idx_r    <= idx_nxt;
         cmd_r    <= cmd_nxt;
         cmd_ok_r <= cmd_ok_nxt;
         rd_r     <= rd_nxt;
         ara_r    <= ara_nxt;
         tx_r     <= tx_nxt;
         txi_r    <= txi_nxt;
         crc_r    <= crc_nxt;
         wlo_r    <= wlo_nxt;
         whi_r    <= whi_nxt;
         dcnt_r   <= dcnt_nxt;
         pend_r   <= pend_nxt;
         hack_r   <= hack_nxt;
         oe_n_r   <= oe_n_nxt;
         alert_r  <= alert_nxt;
         cml_r    <= cml_nxt;
         own_r    <= own_nxt;
         strap_r  <= strap_nxt;
         sp_r     <= sp_nxt;
         mh_r     <= mh_nxt;
         ml_r     <= ml_nxt;
         sc_r     <= sc_nxt;
      end
   end

   // Output flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_o       <= 1'b0;
         sda_oe_n    <= 1'b1;
         alert_o     <= 1'b0;
         alert_oe_n  <= 1'b1;
         setpoint    <= `RST_SETPOINT;
         margin_hi   <= `RST_MARGIN_HI;
         margin_lo   <= `RST_MARGIN_LO;
         scale_ratio <= `RST_SCALE;
         cml_err     <= 1'b0;
      end else begin
         sda_o       <= 1'b0;
         sda_oe_n    <= oe_n_nxt;
         alert_o     <= 1'b0;
         alert_oe_n  <= ~alert_nxt;
         setpoint    <= sp_nxt;
         margin_hi   <= mh_nxt;
         margin_lo   <= ml_nxt;
         scale_ratio <= sc_nxt;
         cml_err     <= cml_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_byte_done;
      st_r == ST_RXB && fall_ev && cnt_r == `BITS_BYTE && !start_ev &&
      !stop_ev;
   endsequence
   // Ack slot lasts far longer than eight cycles at the bus timing
   sequence s_ack_slot;
      st_r == ST_RACK && !sda_oe_n;
   endsequence
   a_start_seen: assert property (start_ev |=> st_r == ST_RXB && cnt_r == 4'h0)
      else $error("start not taken");
   a_stop_seen: assert property (stop_ev |=> st_r == ST_IDLE && sda_oe_n)
      else $error("stop not taken");
   a_bit_count: assert property (st_r == ST_RXB && rise_ev && !start_ev && !stop_ev |=> cnt_r == $past(cnt_r) + 4'h1)
      else $error("bit count wrong");
   a_ack_low: assert property (s_byte_done ##1 st_r == ST_RACK |-> s_ack_slot [*8])
      else $error("ack not held low");
   a_idle_quiet: assert property (st_r == ST_IDLE || st_r == ST_SKIP |-> sda_oe_n)
      else $error("drives bus unaddressed");
   a_pec_flag: assert property (pec_bad |=> cml_err && $stable(setpoint))
      else $error("bad check not flagged");
   a_commit_word: assert property (commit && cmd_r == `OFS_SETPOINT |=> setpoint == {$past(whi_r), $past(wlo_r)})
      else $error("set-point not committed");
   a_lost_release: assert property (lost |=> sda_oe_n && st_r == ST_SKIP)
      else $error("loser still drives");
   a_alert_clear: assert property (ara_done && !alert_req |=> alert_oe_n)
      else $error("alert not released");
   a_addr_range: assert property (strap_r |-> own_r >= `ADDR_BASE && own_r <= `ADDR_BASE + 7'h0f)
      else $error("address out of range");
endmodule
`default_nettype wire

// [pmbus_slave_pkg.sv]
// Types and check-byte function of the management slave
`include "pmbus_slave_regs.svh"
package pmbus_slave_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RXB  = 3'b001,
      ST_RACK = 3'b010,
      ST_TXB  = 3'b011,
      ST_TACK = 3'b100,
      ST_SKIP = 3'b101
   } link_state_e;
   typedef logic [7:0] byte_t;
   // One byte step of the CRC-8 check
   function automatic byte_t crc8_step(byte_t c, byte_t d);
      byte_t x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ((x << 1) ^ `CRC_POLY) : (x << 1);
      end
      return x;
   endfunction
endpackage

// [pmbus_slave_regs.svh]
// Command codes, reset values and timing constants of the management slave
// Overview of operation
// - Works at 100 kHz and 400 kHz clocks
// - Address is 30h plus four-bit strap code
// - Data falling while clock high starts transfer
// - Data rising while clock high stops transfer
// - Host clocks; eight bits plus acknowledge slot
// - Device acknowledges each byte by pulling low, except unknown commands and surplus bytes
// - Only matching address, or alert response read while alert pending, gets answers; else silent
// - Write commits on falling edge after check LSB, or at stop without check
// - Seven transfer types, each with optional check
// - Acknowledge is zero; host ends reads with one
// - Reads append check byte; write checks verified
// - Bad write check discards command, flags error
// - Messages accepted with or without check byte
// - Host services alert via alert response read
// - Alert answer carries own address in MSBs
// - Lowest address wins; losers stop driving
// - Alert released after address sent successfully
// - Set-point and margins weigh 2 mV per bit
// - Loop scale weighs one thousandth per bit
`ifndef PMBUS_SLAVE_REGS_SVH
`define PMBUS_SLAVE_REGS_SVH
`define ADDR_BASE      7'h30
`define ARA_ADDR       7'h0c
`define OFS_SETPOINT   8'h21
`define OFS_MARGIN_HI  8'h25
`define OFS_MARGIN_LO  8'h26
`define OFS_SCALE      8'h29
`define OFS_VOUT_MEAS  8'h8b
`define CMD_CLR_FAULT  8'h03
`define CMD_STATUS     8'h78
`define CMD_BLOCK_ID   8'h9a
`define RST_SETPOINT   16'h0384
`define RST_MARGIN_HI  16'h03de
`define RST_MARGIN_LO  16'h032a
`define RST_SCALE      16'h014d
`define VOUT_LSB_UV    2000
`define SCALE_LSB_PPM  1000
`define CLK_KHZ        10000
`define SCL_STD_KHZ    100
`define SCL_FAST_KHZ   400
`define SCL_HALF_CYC   ((`CLK_KHZ) / (2 * `SCL_FAST_KHZ))
`define CRC_POLY       8'h07
`define STAT_CML_BIT   1
`define BLOCK_LEN      8'h02
`define LEN_BAD        2'h3
`define BITS_BYTE      4'h8
`endif

// [tb.sv]
// Self-checking bench for the management bus slave
`timescale 1ns/10ps
`default_nettype none
module tb;
   import pmbus_slave_pkg::*;
   logic        clk, rst_n, scl, sda_h, sda, sda_o, sda_oe_n;
   logic        alert_o, alert_oe_n, alert_req, cml_err;
   logic [3:0]  addr_code;
   logic [15:0] meas_vout, setpoint, margin_hi, margin_lo, scale_ratio;
   logic [6:0]  own;
   logic [7:0]  pc;
   int          fails, compares;
   assign sda = sda_h & (sda_oe_n | sda_o);
   pmbus_host_model host_u (.clk(clk), .sda(sda), .scl(scl), .sda_h(sda_h));
   pmbus_slave_interface dut_u (.clk(clk), .rst_n(rst_n), .scl(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .alert_o(alert_o),
      .alert_oe_n(alert_oe_n), .addr_code(addr_code), .alert_req(alert_req),
      .meas_vout(meas_vout), .setpoint(setpoint), .margin_hi(margin_hi),
      .margin_lo(margin_lo), .scale_ratio(scale_ratio), .cml_err(cml_err));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
      return x;
   endfunction
   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic a;
      host_u.wr(b, a);
      pc = crc(pc, b);
      chk(a, exp_ack);
   endtask
   task automatic wr_tx(input logic [7:0] cmd, input logic [15:0] v,
                        input int nb, input logic pec, input logic bad);
      pc = 8'h00;
      host_u.start();
      send({own, 1'b0}, 1'b0);
      send(cmd, 1'b0);
      for (int i = 0; i < nb; i++) send(v[8*i +: 8], 1'b0);
      if (pec) send(pc ^ {7'h00, bad}, 1'b0);
      host_u.stop();
   endtask
   task automatic rd_tx(input logic wc, input logic [7:0] cmd, input int nb,
                        output logic [31:0] v);
      logic [7:0] d;
      pc = 8'h00;
      v = '0;
      host_u.start();
      if (wc) begin
         send({own, 1'b0}, 1'b0);
         send(cmd, 1'b0);
         host_u.start();
      end
      send({own, 1'b1}, 1'b0);
      for (int i = 0; i < nb; i++) begin
         host_u.rd(8'hff, 1'b0, d);
         pc = crc(pc, d);
         v[8*i +: 8] = d;
      end
      host_u.rd(8'hff, 1'b1, d);
      chk(d, pc);
      host_u.stop();
   endtask
   task automatic ara(input logic [7:0] comp, output logic [7:0] d);
      logic a;
      host_u.start();
      host_u.wr({7'h0c, 1'b1}, a);
      host_u.rd(comp, 1'b1, d);
      host_u.stop();
   endtask
   initial begin
      #8_000_000;
      fails++;
      wrap_up();
   end
   initial begin
      logic [31:0] v;
      logic [7:0]  d;
      logic [15:0] tv [4];
      logic [7:0]  cm [4];
      cm = '{8'h21, 8'h25, 8'h26, 8'h29};
      void'($urandom(32'h782e));
      rst_n = 1'b0;
      alert_req = 1'b0;
      addr_code = 4'($urandom);
      meas_vout = 16'($urandom);
      own = {3'b011, addr_code};
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      chk(setpoint, 16'h0384);
      chk(margin_hi, 16'h03de);
      chk(margin_lo, 16'h032a);
      chk(scale_ratio, 16'h014d);
      chk(cml_err, 1'b0);
      chk(alert_o, 1'b0);
      $display("test reset done");
      for (int k = 0; k < 4; k++) begin
         tv[k] = 16'($urandom);
         wr_tx(cm[k], tv[k], 2, k[0], 1'b0);
         rd_tx(1'b1, cm[k], 2, v);
         chk(v[15:0], tv[k]);
      end
      chk(setpoint, tv[0]);
      chk(margin_hi, tv[1]);
      chk(margin_lo, tv[2]);
      chk(scale_ratio, tv[3]);
      $display("test registers done");
      pc = 8'h00;
      host_u.start();
      send({own ^ 7'h01, 1'b0}, 1'b1);
      host_u.stop();
      rd_tx(1'b1, 8'h8b, 2, v);
      chk(v[15:0], meas_vout);
      rd_tx(1'b1, 8'h9a, 3, v);
      chk(v[23:0], 24'h5a0102);
      $display("test address and reads done");
      wr_tx(8'h21, ~tv[0], 2, 1'b1, 1'b1);
      chk(setpoint, tv[0]);
      chk(cml_err, 1'b1);
      rd_tx(1'b1, 8'h78, 1, v);
      chk(v[1], 1'b1);
      rd_tx(1'b0, 8'h00, 1, v);
      chk(v[1], 1'b1);
      wr_tx(8'h78, 16'h0002, 1, 1'b0, 1'b0);
      chk(cml_err, 1'b0);
      wr_tx(8'h21, ~tv[0], 2, 1'b1, 1'b1);
      chk(cml_err, 1'b1);
      wr_tx(8'h03, 16'h0000, 0, 1'b1, 1'b0);
      chk(cml_err, 1'b0);
      $display("test check byte done");
      alert_req = 1'b1;
      @(negedge clk);
      alert_req = 1'b0;
      repeat (3) @(negedge clk);
      chk(alert_oe_n, 1'b0);
      ara(8'h21, d);
      chk(d, 8'h21);
      chk(alert_oe_n, 1'b0);
      ara(8'hff, d);
      chk(d[7:1], own);
      repeat (4) @(negedge clk);
      chk(alert_oe_n, 1'b1);
      $display("test alert done");
      wrap_up();
   end
endmodule
`default_nettype wire
